/* File: rtl/rps_defs.vh */
// named constants for the reset and power saving controller
// assumes inclusion by bare name from rtl/ design files
`ifndef RPS_DEFS_VH
`define RPS_DEFS_VH
// reset qualification, crystal clocks with the oscillator stable
`define RPS_QUAL_CLKS 24
// stretched internal reset length in clock cycles
`define RPS_STRETCH_CLKS 2048
// default oscillator stabilisation count after power-down wake
`define RPS_OSC_STAB_CLKS 8192
// program counter restart address
`define RPS_RESET_VECTOR 16'h0000
// power state codes
`define RPS_ST_RUN 2'h0
`define RPS_ST_IDLE 2'h1
`define RPS_ST_PDOWN 2'h2
`define RPS_ST_WAKE 2'h3
`endif

/* File: rtl/rps_reset_filter.v */
// reset qualifier and stretcher for the reset and power saving controller
// assumes pins already synchronous to clk_sys and the oscillator stable
`timescale 1ns/1ns
`include "rps_defs.vh"
module rps_reset_filter #(
	parameter QUAL_CLKS = `RPS_QUAL_CLKS,
	parameter STRETCH_CLKS = `RPS_STRETCH_CLKS
) (
	clk_sys,
	sys_rst,
	rst_req,
	rst_active_r
);
	input wire clk_sys; // crystal clock
	input wire sys_rst; // power-on init of this filter
	input wire rst_req; // combined reset request level
	output reg rst_active_r; // stretched internal reset

	localparam QW = 6; // holds QUAL_CLKS
	localparam SW = 12; // holds STRETCH_CLKS - 1
	// full-width terminal counts, cut on purpose to the counters
	localparam [31:0] QUAL_LAST_W = QUAL_CLKS - 1;
	localparam [31:0] STR_LAST_W = STRETCH_CLKS - 1;
	localparam [QW-1:0] QUAL_LAST = QUAL_LAST_W[QW-1:0];
	localparam [SW-1:0] STR_LAST = STR_LAST_W[SW-1:0];

	reg [QW-1:0] qual_r; // cycles the request has been held
	reg [QW-1:0] qual_nxt;
	reg [SW-1:0] str_r; // cycles left in the stretch
	reg [SW-1:0] str_nxt;
	reg rst_active_nxt;
	reg qualified; // request held long enough

	// qualify then stretch; a short glitch never reaches the core
	always @* begin
		qualified = 1'b0;
		qual_nxt = qual_r;
		if (!rst_req) begin
			qual_nxt = {QW{1'b0}};
		end else if (qual_r == QUAL_LAST) begin
			qualified = 1'b1;
		end else begin
			qual_nxt = qual_r + 1'b1;
		end
		str_nxt = str_r;
		rst_active_nxt = rst_active_r;
		if (qualified) begin
			// a held pin keeps reloading, so stretch ends after release
			str_nxt = STR_LAST;
			rst_active_nxt = 1'b1;
		end else if (rst_active_r) begin
			if (str_r == {SW{1'b0}}) begin
				rst_active_nxt = 1'b0;
			end else begin
				str_nxt = str_r - 1'b1;
			end
		end
	end

	// state update
	always @(posedge clk_sys) begin
		if (sys_rst) begin
			qual_r <= {QW{1'b0}};
			str_r <= STR_LAST;
			rst_active_r <= 1'b1; // power-on counts as a reset
		end else begin
			qual_r <= qual_nxt;
			str_r <= str_nxt;
			rst_active_r <= rst_active_nxt;
		end
	end
endmodule

/* File: rtl/rps_top.v */
// reset and power saving controller: reset pins, standby, idle, power-down
// assumes pins synchronous to clk_sys; clk_sys is the crystal clock and
// keeps ticking this block even while the oscillator stop output is high
//
// Overview of operation
// - either reset pin alone resets the device
// - reset held 24 clocks once oscillator stable
// - internal reset lasts 2048 clock cycles
// - standby bit set enters standby mode
// - standby gates only acquisition and display clocks
// - standby combines with idle or power-down
// - idle bit gates cpu, acquisition, display clocks
// - idle freezes cpu and registers, keeps pins
// - enabled interrupt clears idle bit, resumes
// - analog compare interrupt ends idle if enabled
// - in idle reset needs only 24 clocks
// - reset inits registers, display memory, pc zero
// - power-down bit stops the crystal oscillator
// - power-down keeps registers and data memory
// - power-down holds port pins at register values
// - analog compare interrupt wakes from power-down
// - hardware reset also ends power-down
`timescale 1ns/1ns
`include "rps_defs.vh"
module rps_top #(
	parameter QUAL_CLKS = `RPS_QUAL_CLKS,
	parameter STRETCH_CLKS = `RPS_STRETCH_CLKS,
	parameter OSC_STAB_CLKS = `RPS_OSC_STAB_CLKS,
	parameter STAB_W = 16
) (
	clk_sys,
	sys_rst,
	reset_pin_hi,
	reset_pin_n,
	standby_wr,
	standby_wdata,
	power_control_register_wr,
	idle_request_wdata,
	powerdown_request_wdata,
	irq_pending,
	acmp_irq,
	acmp_wake_en,
	standby_bit_r,
	idle_request_bit_r,
	powerdown_request_bit_r,
	int_rst_r,
	init_regs_r,
	pc_load_r,
	pc_value_r,
	osc_stop_r,
	clk_en_cpu_r,
	clk_en_acq_r,
	clk_en_disp_r,
	clk_en_periph_r,
	clk_en_adc_r,
	aux_mem_lost_r,
	hold_outputs_r,
	wake_irq_r
);
	input wire clk_sys; // crystal clock, 50 ns
	input wire sys_rst; // power-on init, sync active high
	input wire reset_pin_hi; // active-high reset pin
	input wire reset_pin_n; // active-low reset pin
	input wire standby_wr; // write strobe, bank select register
	input wire standby_wdata; // low-activity select bit value
	input wire power_control_register_wr; // write strobe, power control register
	input wire idle_request_wdata; // idle request bit value
	input wire powerdown_request_wdata; // power-down request bit value
	input wire irq_pending; // any enabled interrupt asserted
	input wire acmp_irq; // analog compare threshold interrupt
	input wire acmp_wake_en; // analog compare configured to wake
	output reg standby_bit_r; // bank select low-activity bit
	output reg idle_request_bit_r; // power control idle bit
	output reg powerdown_request_bit_r; // power control power-down bit
	output reg int_rst_r; // internal reset to the device
	output reg init_regs_r; // load predefined register values
	output reg pc_load_r; // load program counter
	output reg [15:0] pc_value_r; // restart address
	output reg osc_stop_r; // stop the crystal oscillator
	output reg clk_en_cpu_r; // cpu core clock enable
	output reg clk_en_acq_r; // acquisition clock enable
	output reg clk_en_disp_r; // display clock enable
	output reg clk_en_periph_r; // memory, bus, uart, timers, wdt, pwm
	output reg clk_en_adc_r; // analog compare adc clock enable
	output reg aux_mem_lost_r; // aux/display memory invalid
	output reg hold_outputs_r; // pins frozen at register values
	output reg wake_irq_r; // one pulse: service the wake interrupt

	// full-width settle count, cut on purpose to the counter width
	localparam [31:0] STAB_LAST_W = OSC_STAB_CLKS - 1;
	localparam [STAB_W-1:0] STAB_LAST = STAB_LAST_W[STAB_W-1:0];

	wire rst_req; // combined pin request
	wire rst_stretch; // qualified and stretched reset
	wire wake_any; // any wake source active

	reg [1:0] state_r; // power state
	reg [1:0] state_nxt;
	reg [STAB_W-1:0] stab_r; // oscillator settle counter
	reg [STAB_W-1:0] stab_nxt;
	reg idle_nxt;
	reg pd_nxt;
	reg wake_nxt;
	reg lost_nxt;

	// pins ORed: the idle one of the two never masks the other
	assign rst_req = reset_pin_hi | ~reset_pin_n;

	// enabled interrupt or configured analog compare interrupt
	assign wake_any = irq_pending | (acmp_irq & acmp_wake_en);

	rps_reset_filter #(
		.QUAL_CLKS(QUAL_CLKS),
		.STRETCH_CLKS(STRETCH_CLKS)
	) u_filter (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.rst_req(rst_req),
		.rst_active_r(rst_stretch)
	);

	// power state machine
	always @* begin
		state_nxt = state_r;
		stab_nxt = stab_r;
		idle_nxt = idle_request_bit_r;
		pd_nxt = powerdown_request_bit_r;
		wake_nxt = 1'b0;
		lost_nxt = aux_mem_lost_r;
		case (state_r)
		`RPS_ST_RUN: begin
			// power-down wins if software sets both bits at once
			if (power_control_register_wr && powerdown_request_wdata) begin
				pd_nxt = 1'b1;
				idle_nxt = idle_request_wdata;
				state_nxt = `RPS_ST_PDOWN;
			end else if (power_control_register_wr && idle_request_wdata) begin
				idle_nxt = 1'b1;
				state_nxt = `RPS_ST_IDLE;
			end else if (power_control_register_wr) begin
				idle_nxt = 1'b0;
				pd_nxt = 1'b0;
			end
		end
		`RPS_ST_IDLE: begin
			if (wake_any) begin
				idle_nxt = 1'b0;
				wake_nxt = 1'b1;
				state_nxt = `RPS_ST_RUN;
			end
		end
		`RPS_ST_PDOWN: begin
			lost_nxt = 1'b1;
			if (wake_any) begin
				stab_nxt = STAB_LAST;
				state_nxt = `RPS_ST_WAKE;
			end
		end
		`RPS_ST_WAKE: begin
			// oscillator restarting: gated clocks stay off meanwhile
			if (stab_r == {STAB_W{1'b0}}) begin
				pd_nxt = 1'b0;
				idle_nxt = 1'b0;
				wake_nxt = 1'b1;
				state_nxt = `RPS_ST_RUN;
			end else begin
				stab_nxt = stab_r - 1'b1;
			end
		end
		default: begin
			state_nxt = `RPS_ST_RUN;
		end
		endcase
	end

	// state, bits and outputs; internal reset overrides all modes
	always @(posedge clk_sys) begin
		if (sys_rst || rst_stretch) begin
			// reset ends idle and power-down alike
			state_r <= `RPS_ST_RUN;
			stab_r <= {STAB_W{1'b0}};
			standby_bit_r <= 1'b0;
			idle_request_bit_r <= 1'b0;
			powerdown_request_bit_r <= 1'b0;
			int_rst_r <= 1'b1;
			init_regs_r <= 1'b1;
			pc_load_r <= 1'b1;
			pc_value_r <= `RPS_RESET_VECTOR;
			osc_stop_r <= 1'b0;
			clk_en_cpu_r <= 1'b0;
			clk_en_acq_r <= 1'b0;
			clk_en_disp_r <= 1'b0;
			clk_en_periph_r <= 1'b0;
			clk_en_adc_r <= 1'b0;
			aux_mem_lost_r <= 1'b0; // display memory reinitialised
			hold_outputs_r <= 1'b0;
			wake_irq_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			stab_r <= stab_nxt;
			if (standby_wr) begin
				standby_bit_r <= standby_wdata;
			end
			idle_request_bit_r <= idle_nxt;
			powerdown_request_bit_r <= pd_nxt;
			int_rst_r <= 1'b0;
			init_regs_r <= 1'b0;
			pc_load_r <= 1'b0;
			pc_value_r <= `RPS_RESET_VECTOR;
			// oscillator stops only in power-down proper
			osc_stop_r <= (state_nxt == `RPS_ST_PDOWN);
			// cpu frozen in idle, power-down and settle; wake runs it
			clk_en_cpu_r <= (state_nxt == `RPS_ST_RUN);
			// standby keeps acq/disp gated even after a wake
			clk_en_acq_r <= (state_nxt == `RPS_ST_RUN) &&
				!(standby_wr ? standby_wdata : standby_bit_r);
			clk_en_disp_r <= (state_nxt == `RPS_ST_RUN) &&
				!(standby_wr ? standby_wdata : standby_bit_r);
			// peripherals run in run and idle, stop with the oscillator
			clk_en_periph_r <= (state_nxt == `RPS_ST_RUN) ||
				(state_nxt == `RPS_ST_IDLE);
			clk_en_adc_r <= (state_nxt == `RPS_ST_RUN) ||
				(state_nxt == `RPS_ST_IDLE);
			// aux memory stays invalid until the next reset reloads it
			aux_mem_lost_r <= lost_nxt;
			// pins frozen whenever the cpu clock is gated outside reset; reset gates it with pins free
			hold_outputs_r <= (state_nxt != `RPS_ST_RUN);
			wake_irq_r <= wake_nxt;
		end
	end
endmodule

/* File: dv/rps_props.sv */
// port checker for the reset and power saving controller
// assumes a bind onto rps_top; one clock domain, clk_sys
`timescale 1ns/1ns
module rps_props #(
	parameter QUAL_CLKS = 24,
	parameter STRETCH_CLKS = 2048,
	parameter OSC_STAB_CLKS = 8192
) (
	input wire clk_sys,
	input wire sys_rst,
	input wire reset_pin_hi,
	input wire reset_pin_n,
	input wire standby_wr,
	input wire standby_wdata,
	input wire power_control_register_wr,
	input wire idle_request_wdata,
	input wire powerdown_request_wdata,
	input wire irq_pending,
	input wire acmp_irq,
	input wire acmp_wake_en,
	input wire standby_bit_r,
	input wire idle_request_bit_r,
	input wire powerdown_request_bit_r,
	input wire int_rst_r,
	input wire pc_load_r,
	input wire [15:0] pc_value_r,
	input wire osc_stop_r,
	input wire clk_en_cpu_r,
	input wire clk_en_acq_r,
	input wire clk_en_periph_r,
	input wire hold_outputs_r,
	input wire wake_irq_r
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	wire req = reset_pin_hi | ~reset_pin_n; // combined pin request
	wire run = ~hold_outputs_r & ~int_rst_r; // writes are taken here
	wire idle_request_bit = idle_request_bit_r & ~powerdown_request_bit_r & ~int_rst_r;
	// oscillator restarting after a power-down wake
	wire settling = powerdown_request_bit_r & ~osc_stop_r & ~int_rst_r;
	reg [11:0] q_cnt_r = 12'h000; // consecutive request cycles
	reg [15:0] h_cnt_r = 16'h0000; // cycles internal reset stood high
	reg [15:0] s_cnt_r = 16'h0000; // cycles spent settling
	// run lengths; q saturates so a held pin never wraps; the others
	// clear in power-on init, so an unknown reset level never lingers
	always @(posedge clk_sys) begin
		q_cnt_r <= req ?
			q_cnt_r + {11'h000, q_cnt_r != 12'hfff} : 12'h000;
		if (sys_rst) begin
			h_cnt_r <= 16'h0000;
			s_cnt_r <= 16'h0000;
		end else begin
			h_cnt_r <= int_rst_r ? h_cnt_r + 16'h0001 : 16'h0000;
			s_cnt_r <= settling ? s_cnt_r + 16'h0001 : 16'h0000;
		end
	end
	a_pin_qual: assert property (
		q_cnt_r == QUAL_CLKS |-> ##[0:2] int_rst_r)
		else $error("qualified pin gave no reset");
	a_stretch_len: assert property (
		$fell(int_rst_r) |-> h_cnt_r >= STRETCH_CLKS)
		else $error("internal reset too short");
	a_reset_init: assert property (
		int_rst_r |-> pc_load_r && !clk_en_cpu_r &&
		pc_value_r == 16'h0000)
		else $error("reset without restart load");
	a_standby_gate: assert property (
		run && standby_wr && standby_wdata |=> standby_bit_r &&
		!clk_en_acq_r && clk_en_cpu_r && !osc_stop_r)
		else $error("standby gating wrong");
	a_idle_gate: assert property (
		run && power_control_register_wr && idle_request_wdata &&
		!powerdown_request_wdata |=> idle_request_bit && !clk_en_cpu_r &&
		clk_en_periph_r && hold_outputs_r)
		else $error("idle gating wrong");
	a_idle_wake: assert property (
		idle_request_bit && irq_pending |=> !idle_request_bit_r && clk_en_cpu_r &&
		(clk_en_acq_r != standby_bit_r))
		else $error("idle wake wrong");
	a_acmp_idle: assert property (
		idle_request_bit && acmp_irq && !irq_pending |=>
		(idle_request_bit_r != $past(acmp_wake_en)) ##1 !wake_irq_r)
		else $error("analog compare idle wake wrong");
	a_pd_entry: assert property (
		run && power_control_register_wr && powerdown_request_wdata |=> osc_stop_r &&
		!clk_en_periph_r && hold_outputs_r)
		else $error("power-down entry wrong");
	a_pd_wake: assert property (
		osc_stop_r && acmp_irq && acmp_wake_en && !int_rst_r |=>
		!osc_stop_r && !clk_en_cpu_r)
		else $error("power-down wake wrong");
	a_settle_len: assert property (
		s_cnt_r <= OSC_STAB_CLKS + 2)
		else $error("oscillator settle too long");
	a_settle_done: assert property (
		$fell(settling) && !int_rst_r |-> wake_irq_r && clk_en_cpu_r &&
		s_cnt_r >= OSC_STAB_CLKS - 1)
		else $error("settle end wrong");
endmodule

/* File: dv/rps_ext_model.sv */
// far side: reset pins, enabled interrupt and analog compare sources
// assumes clk_sys from the bench; all changes land just after an edge
`timescale 1ns/1ns
module rps_ext_model (
	input wire clk_sys,
	output reg reset_pin_hi,
	output reg reset_pin_n,
	output reg irq_pending,
	output reg acmp_irq
);
	// pins rest at their pad pull levels; software has watchdog and
	// display outputs off before any mode write
	initial begin
		reset_pin_hi = 1'b0;
		reset_pin_n = 1'b1;
		irq_pending = 1'b0;
		acmp_irq = 1'b0;
	end
	// hold one pin asserted n clocks, the other inactive
	task rst_pin(input bit hi_sel, input int n);
		@(posedge clk_sys);
		reset_pin_hi <= hi_sel;
		reset_pin_n <= hi_sel;
		repeat (n) @(posedge clk_sys);
		reset_pin_hi <= 1'b0;
		reset_pin_n <= 1'b1;
		#1;
	endtask
	// level, not edge: a stopped clock still sees it
	task wake(input bit acmp, input int n);
		@(posedge clk_sys);
		irq_pending <= !acmp;
		acmp_irq <= acmp;
		repeat (n) @(posedge clk_sys);
		irq_pending <= 1'b0;
		acmp_irq <= 1'b0;
		#1;
	endtask
endmodule

/* File: dv/tb_rps_top.sv */
// bench for the reset and power saving controller
// assumes rps_props and rps_ext_model are compiled before it
`timescale 1ns/1ns
module tb_rps_top;
	localparam int STR = 16; // short stretch keeps the run brief
	localparam int OSC = 4; // short oscillator settle
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic standby_wr = 1'b0;
	logic standby_wdata = 1'b0;
	logic power_control_register_wr = 1'b0;
	logic idle_request_wdata = 1'b0;
	logic powerdown_request_wdata = 1'b0;
	logic acmp_wake_en = 1'b0;
	wire reset_pin_hi, reset_pin_n, irq_pending, acmp_irq;
	wire standby_bit_r, idle_request_bit_r, powerdown_request_bit_r;
	wire int_rst_r, init_regs_r, pc_load_r, osc_stop_r, clk_en_cpu_r;
	wire clk_en_acq_r, clk_en_disp_r, clk_en_periph_r, clk_en_adc_r;
	wire aux_mem_lost_r, hold_outputs_r, wake_irq_r;
	wire [15:0] pc_value_r;
	int miscompares = 0;
	int samples_checked = 0;
	int cyc = 0; // hang guard
	rps_top #(.STRETCH_CLKS(STR), .OSC_STAB_CLKS(OSC)) dut (.*);
	rps_ext_model ext (.*);
	// 50 ns crystal clock
	initial forever #25 clk_sys = ~clk_sys;
	task chk(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask
	task end_sim;
		$display("checked %0d mismatched %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// one-cycle strobe; returns after the taking edge has landed
	task wr_power_control_register(input logic idle_request_bit, input logic pd);
		@(posedge clk_sys);
		power_control_register_wr <= 1'b1;
		idle_request_wdata <= idle_request_bit;
		powerdown_request_wdata <= pd;
		@(posedge clk_sys);
		power_control_register_wr <= 1'b0;
		#1;
	endtask
	task wr_stby(input logic v);
		@(posedge clk_sys);
		standby_wr <= 1'b1;
		standby_wdata <= v;
		@(posedge clk_sys);
		standby_wr <= 1'b0;
		#1;
	endtask
	// wait, bounded, for internal reset (cpu 0) or cpu clock enable
	// (cpu 1) to reach v; n counts the edges; a run-out is a mismatch
	task wait_for(input logic cpu, input logic v, output int n);
		n = 0;
		while ((cpu ? clk_en_cpu_r : int_rst_r) !== v && n < 100) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		if (n >= 100) begin
			miscompares++;
			$display("FAIL wait expected %b seen %b", v, ~v);
			end_sim();
		end
	endtask
	// cut a hang short
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 2000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		int n;
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		wait_for(1'b0, 1'b0, n);
		chk("stretch", 1'b1, n >= STR && n <= STR + 3);
		ext.rst_pin(1'b1, 23);
		repeat (2) @(posedge clk_sys);
		#1;
		chk("short pin", 1'b0, int_rst_r);
		ext.rst_pin(1'b0, 24);
		@(posedge clk_sys);
		#1;
		chk("low pin reset", 1'b1, int_rst_r);
		chk("init regs", 1'b1, init_regs_r);
		wait_for(1'b0, 1'b0, n);
		chk("pin stretch", 1'b1, n >= STR - 1 && n <= STR + 1);
		$display("test reset pins done");
		wr_stby(1'b1);
		chk("standby acq", 1'b0, clk_en_acq_r);
		wr_power_control_register(1'b1, 1'b0);
		chk("idle cpu", 1'b0, clk_en_cpu_r);
		chk("idle adc", 1'b1, clk_en_adc_r);
		chk("idle pins", 1'b1, hold_outputs_r);
		ext.wake(1'b0, 1);
		chk("idle bit", 1'b0, idle_request_bit_r);
		chk("wake pulse", 1'b1, wake_irq_r);
		chk("acq gated", 1'b0, clk_en_acq_r);
		wr_stby(1'b0);
		chk("disp back", 1'b1, clk_en_disp_r);
		wr_power_control_register(1'b1, 1'b0);
		ext.wake(1'b1, 3);
		chk("compare off", 1'b1, idle_request_bit_r);
		@(posedge clk_sys);
		acmp_wake_en <= 1'b1;
		ext.wake(1'b1, 1);
		chk("compare wake", 1'b0, idle_request_bit_r);
		wr_power_control_register(1'b1, 1'b0);
		ext.rst_pin(1'b1, 24);
		@(posedge clk_sys);
		#1;
		chk("idle rst on", 1'b1, int_rst_r);
		wait_for(1'b0, 1'b0, n);
		chk("idle reset", 1'b1, n >= STR);
		chk("idle init", 1'b0, idle_request_bit_r);
		$display("test idle done");
		wr_power_control_register(1'b1, 1'b1);
		chk("osc stop", 1'b1, osc_stop_r);
		chk("pd adc", 1'b0, clk_en_adc_r);
		@(posedge clk_sys);
		#1;
		chk("aux lost", 1'b1, aux_mem_lost_r);
		chk("pins held", 1'b1, hold_outputs_r);
		ext.wake(1'b1, 1);
		chk("osc runs", 1'b0, osc_stop_r);
		wait_for(1'b1, 1'b1, n);
		chk("settle", 1'b1, n >= OSC - 1 && n <= OSC + 2);
		chk("pd bit", 1'b0, powerdown_request_bit_r);
		wr_power_control_register(1'b0, 1'b1);
		ext.rst_pin(1'b0, 24);
		@(posedge clk_sys);
		#1;
		chk("pd rst on", 1'b1, int_rst_r);
		wait_for(1'b0, 1'b0, n);
		chk("pd reset", 1'b1, n >= STR);
		chk("pd osc", 1'b0, osc_stop_r);
		$display("test power-down done");
		end_sim();
	end
endmodule
bind rps_top rps_props #(.QUAL_CLKS(QUAL_CLKS), .STRETCH_CLKS(STRETCH_CLKS),
	.OSC_STAB_CLKS(OSC_STAB_CLKS)) chk_i (.*);
